/* File: rtl/sirc_pkg.sv */
package sirc_pkg;
    // ****************************************************************
    // Register map: logical device number and register index
    // ****************************************************************
    localparam logic [3:0] LDN_FIRST_PORT = 4'h4;
    localparam logic [3:0] LDN_SECOND_PORT = 4'h5;
    localparam logic [7:0] IDX_PORT_MODE = 8'hF0;
    localparam logic [7:0] IDX_IR_OPTION = 8'hF1;
    localparam logic [7:0] IDX_HD_TIMEOUT = 8'hF2;

    // ****************************************************************
    // Reset values and writable-bit masks
    // ****************************************************************
    localparam logic [7:0] RST_PORT_MODE = 8'h00;
    localparam logic [7:0] RST_IR_OPTION = 8'h02;
    localparam logic [7:0] RST_HD_TIMEOUT = 8'h03;
    localparam logic [7:0] MASK_FIRST_MODE = 8'h83;
    localparam logic [7:0] MASK_SECOND_MODE = 8'h03;
    localparam logic [7:0] MASK_IR_OPTION = 8'h7F;
    localparam logic [7:0] MASK_HD_TIMEOUT = 8'hFF;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_MIDI = 0;
    localparam int BIT_HIGH_SPEED = 1;
    localparam int BIT_SHARE_IRQ = 7;
    localparam int BIT_RX_POL = 0;
    localparam int BIT_TX_POL = 1;
    localparam int BIT_HALF_DUPLEX = 2;
    localparam int BIT_MODE_LO = 3;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_IR_LOC = 6;

    // ****************************************************************
    // Link formats of the infrared mode field
    // ****************************************************************
    typedef enum logic [2:0] {
        IRM_STANDARD = 3'h0,
        IRM_IRDA = 3'h1,
        IRM_ASK = 3'h2,
        IRM_RESERVED = 3'h3
    } sirc_irmode_e;

    // ****************************************************************
    // Blanking time unit
    // ****************************************************************
    localparam int BLANK_UNIT_US = 100;
    localparam int CLK_MHZ = 125;
    localparam int BLANK_UNIT_CYCLES = BLANK_UNIT_US * CLK_MHZ;
    localparam int PRE_W = 14;

    // ****************************************************************
    // Receiver blanking states
    // ****************************************************************
    typedef enum logic [2:0] {
        BL_IDLE = 3'h1,
        BL_TX = 3'h2,
        BL_HOLD = 3'h4
    } sirc_blank_e;

    // ****************************************************************
    // Register port request
    // ****************************************************************
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sirc_req_s;
endpackage

/* File: rtl/sirc_top.sv */
// Summary of operation
// - Mode register bit 0 of each port enables MIDI support; off after reset.
// - Mode register bit 1 of each port enables high speed; off after reset.
// - First port mode bit 7 makes both ports drive one common interrupt.
// - Sharing with two assigned pins: both interrupt pins assert on either port.
// - Infrared option bit 0 sets receive polarity; active high after reset.
// - Infrared option bit 1 sets transmit polarity; active low after reset.
// - Infrared option bit 2 selects half duplex; full duplex after reset.
// - Three-bit mode field selects standard, IrDA, ASK-IR or reserved format.
// - Infrared option bit 6 moves infrared signals to the alternate pins.
// - Timeout register extends receiver blanking after transmit by 100 us steps.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module sirc_top
    import sirc_pkg::*;
#(
    parameter int UNIT_CYCLES = BLANK_UNIT_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register port
    input wire sirc_req_s req,
    output logic [7:0] rdata,
    // Port configuration outputs
    output logic first_midi_en,
    output logic first_high_speed,
    output logic second_midi_en,
    output logic second_high_speed,
    output logic [2:0] ir_mode,
    // Interrupt requests from the two serial ports
    input wire logic first_port_irq,
    input wire logic second_port_irq,
    // Interrupt pins
    output logic first_irq_pin,
    output logic second_irq_pin,
    // Second port data on the logic side
    input wire logic second_port_tx,
    output logic second_port_rx,
    output logic rx_blanked,
    // Device pins
    input wire logic second_port_rx_pin,
    input wire logic alt_infrared_rx_pin,
    output logic second_port_tx_pin,
    output logic alt_infrared_tx_pin
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0] p1_mode;
        logic [7:0] p2_mode;
        logic [7:0] ir_opt;
        logic [7:0] hd_tmo;
        logic [7:0] rdata;
        logic [1:0] rx_s1;
        logic [1:0] rx_s2;
        logic rx_out;
        logic tx_main;
        logic tx_alt;
        logic irq1;
        logic irq2;
        sirc_blank_e bl;
        logic [PRE_W-1:0] pre;
        logic [7:0] units;
    } sirc_state_s;

    sirc_state_s q;
    sirc_state_s d;

    // Address match against one logical device and index
    function automatic logic hit(input logic [11:0] a, input logic [3:0] ldn,
                                 input logic [7:0] idx);
        hit = (a[11:8] == ldn) && (a[7:0] == idx);
    endfunction

    // Keep only the implemented bits of a written byte
    function automatic logic [7:0] keep(input logic [7:0] v, input logic [7:0] m);
        keep = v & m;
    endfunction

    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(UNIT_CYCLES - 1);

    // ****************************************************************
    // Decoded settings
    // ****************************************************************
    logic share;
    logic rx_pol_low;
    logic tx_pol_low;
    logic half;
    logic alt_loc;
    logic ir_on;
    logic tx_act;
    logic rx_sel;
    logic tx_idle;

    // Field views of the stored registers
    always_comb begin
        share = q.p1_mode[BIT_SHARE_IRQ];
        rx_pol_low = q.ir_opt[BIT_RX_POL];
        tx_pol_low = q.ir_opt[BIT_TX_POL];
        half = q.ir_opt[BIT_HALF_DUPLEX];
        alt_loc = q.ir_opt[BIT_IR_LOC];
        ir_on = q.ir_opt[BIT_MODE_HI:BIT_MODE_LO] != IRM_STANDARD;
        tx_act = half && ir_on && second_port_tx;
        rx_sel = alt_loc ? q.rx_s2[1] : q.rx_s2[0];
        tx_idle = ir_on ? tx_pol_low : 1'b1;
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // All state moves together; writes land in the registers at the next edge
    always_comb begin
        d = q;
        // Register writes, unused bits dropped so they read back zero
        if (req.wr) begin
            if (hit(req.addr, LDN_FIRST_PORT, IDX_PORT_MODE)) begin
                d.p1_mode = keep(req.wdata, MASK_FIRST_MODE);
            end
            if (hit(req.addr, LDN_SECOND_PORT, IDX_PORT_MODE)) begin
                d.p2_mode = keep(req.wdata, MASK_SECOND_MODE);
            end
            if (hit(req.addr, LDN_SECOND_PORT, IDX_IR_OPTION)) begin
                d.ir_opt = keep(req.wdata, MASK_IR_OPTION);
            end
            if (hit(req.addr, LDN_SECOND_PORT, IDX_HD_TIMEOUT)) begin
                d.hd_tmo = keep(req.wdata, MASK_HD_TIMEOUT);
            end
        end
        // Read data stands only in the cycle after the strobe
        d.rdata = 8'h00;
        if (req.rd) begin
            if (hit(req.addr, LDN_FIRST_PORT, IDX_PORT_MODE)) begin
                d.rdata = q.p1_mode;
            end else if (hit(req.addr, LDN_SECOND_PORT, IDX_PORT_MODE)) begin
                d.rdata = q.p2_mode;
            end else if (hit(req.addr, LDN_SECOND_PORT, IDX_IR_OPTION)) begin
                d.rdata = q.ir_opt;
            end else if (hit(req.addr, LDN_SECOND_PORT, IDX_HD_TIMEOUT)) begin
                d.rdata = q.hd_tmo;
            end
        end
        // Pin synchronisers: first stage feeds only the second
        d.rx_s1 = {alt_infrared_rx_pin, second_port_rx_pin};
        d.rx_s2 = q.rx_s1;
        // Interrupt routing; with sharing either source drives both pins
        d.irq1 = share ? (first_port_irq || second_port_irq) : first_port_irq;
        d.irq2 = share ? (first_port_irq || second_port_irq) : second_port_irq;
        // Receive path: polarity fix and blanking only in infrared formats
        if (ir_on) begin
            d.rx_out = (q.bl != BL_IDLE) ? 1'b0 : (rx_sel ^ rx_pol_low);
        end else begin
            d.rx_out = rx_sel;
        end
        // Transmit path: the unused pin rests at the idle level
        if (ir_on) begin
            d.tx_main = alt_loc ? tx_idle : (second_port_tx ^ tx_pol_low);
            d.tx_alt = alt_loc ? (second_port_tx ^ tx_pol_low) : tx_idle;
        end else begin
            d.tx_main = alt_loc ? tx_idle : second_port_tx;
            d.tx_alt = alt_loc ? second_port_tx : tx_idle;
        end
        // Blanking: while transmitting, then timeout units of 100 us
        unique case (q.bl)
            BL_IDLE: begin
                if (tx_act) begin
                    d.bl = BL_TX;
                end
            end
            BL_TX: begin
                if (!half || !ir_on) begin
                    d.bl = BL_IDLE;
                end else if (!tx_act) begin
                    d.pre = '0;
                    d.units = q.hd_tmo;
                    d.bl = (q.hd_tmo == 8'h00) ? BL_IDLE : BL_HOLD;
                end
            end
            BL_HOLD: begin
                if (!half || !ir_on) begin
                    d.bl = BL_IDLE;
                end else if (tx_act) begin
                    d.bl = BL_TX;
                end else if (q.pre == PRE_LAST) begin
                    d.pre = '0;
                    d.units = q.units - 8'h01;
                    if (q.units == 8'h01) begin
                        d.bl = BL_IDLE;
                    end
                end else begin
                    d.pre = q.pre + PRE_W'(1);
                end
            end
            default: begin
                d.bl = BL_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset loads constants only; pins are re-sampled after release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            q.p1_mode <= RST_PORT_MODE;
            q.p2_mode <= RST_PORT_MODE;
            q.ir_opt <= RST_IR_OPTION;
            q.hd_tmo <= RST_HD_TIMEOUT;
            q.rdata <= 8'h00;
            q.rx_s1 <= 2'h3;
            q.rx_s2 <= 2'h3;
            q.rx_out <= 1'b1;
            q.tx_main <= 1'b1;
            q.tx_alt <= 1'b1;
            q.irq1 <= 1'b0;
            q.irq2 <= 1'b0;
            q.bl <= BL_IDLE;
            q.pre <= '0;
            q.units <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Everything here comes straight from flip-flops, except rx_blanked, which is decoded from the blanking state
    always_comb begin
        rdata = q.rdata;
        first_midi_en = q.p1_mode[BIT_MIDI];
        first_high_speed = q.p1_mode[BIT_HIGH_SPEED];
        second_midi_en = q.p2_mode[BIT_MIDI];
        second_high_speed = q.p2_mode[BIT_HIGH_SPEED];
        ir_mode = q.ir_opt[BIT_MODE_HI:BIT_MODE_LO];
        first_irq_pin = q.irq1;
        second_irq_pin = q.irq2;
        second_port_rx = q.rx_out;
        rx_blanked = q.bl != BL_IDLE;
        second_port_tx_pin = q.tx_main;
        alt_infrared_tx_pin = q.tx_alt;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_wr_first_mode;
        req.wr && hit(req.addr, LDN_FIRST_PORT, IDX_PORT_MODE);
    endsequence

    sequence s_tx_end_zero;
        q.bl == BL_TX && half && ir_on && !tx_act && q.hd_tmo == 8'h00;
    endsequence

    sequence s_tx_start;
        q.bl == BL_IDLE && tx_act;
    endsequence

    chk_midi_write: assert property (
        s_wr_first_mode |=> first_midi_en == $past(req.wdata[BIT_MIDI]))
        else $error("first port MIDI bit not taken from write");

    chk_speed_write: assert property (
        req.wr && hit(req.addr, LDN_SECOND_PORT, IDX_PORT_MODE)
        |=> second_high_speed == $past(req.wdata[BIT_HIGH_SPEED]))
        else $error("second port high speed bit not taken from write");

    chk_share_common: assert property (
        share && second_port_irq |=> first_irq_pin)
        else $error("shared interrupt missing on first pin");

    chk_separate_irq: assert property (
        !share && !first_port_irq |=> !first_irq_pin)
        else $error("first pin asserted without sharing or request");

    chk_both_pins: assert property (
        share && (first_port_irq || second_port_irq) |=> first_irq_pin && second_irq_pin)
        else $error("both interrupt pins not asserted while shared");

    chk_rx_polarity: assert property (
        ir_on && q.bl == BL_IDLE && !alt_loc
        |=> second_port_rx == ($past(q.rx_s2[0]) ^ $past(rx_pol_low)))
        else $error("receive polarity wrong");

    chk_tx_polarity: assert property (
        ir_on && !alt_loc |=> second_port_tx_pin == ($past(second_port_tx) ^ $past(tx_pol_low)))
        else $error("transmit polarity wrong");

    chk_full_duplex: assert property (
        !half |=> q.bl == BL_IDLE)
        else $error("blanking active in full duplex");

    chk_mode_read: assert property (
        req.rd && hit(req.addr, LDN_SECOND_PORT, IDX_IR_OPTION)
        |=> rdata[BIT_MODE_HI:BIT_MODE_LO] == $past(q.ir_opt[BIT_MODE_HI:BIT_MODE_LO]))
        else $error("mode field read back wrong");

    chk_alt_route: assert property (
        alt_loc |=> second_port_tx_pin == $past(tx_idle))
        else $error("main pin not idle while alternate pins selected");

    chk_blank_zero: assert property (
        s_tx_end_zero |=> q.bl == BL_IDLE)
        else $error("zero timeout still blanks after transmit");

    chk_blank_end: assert property (
        q.bl == BL_HOLD && half && ir_on && !tx_act && q.pre == PRE_LAST && q.units == 8'h01
        |=> q.bl == BL_IDLE ##1 (q.bl == BL_IDLE || $past(tx_act)))
        else $error("blanking did not end after last unit");

    chk_unused_zero: assert property (
        s_wr_first_mode |=> (q.p1_mode & ~MASK_FIRST_MODE) == 8'h00
        && (q.p2_mode & ~MASK_SECOND_MODE) == 8'h00)
        else $error("unused mode bits hold ones");

    chk_speed_first: assert property (
        s_wr_first_mode |=> first_high_speed == $past(req.wdata[BIT_HIGH_SPEED]))
        else $error("first port high speed bit not taken from write");

    chk_second_separate: assert property (
        !share && !second_port_irq |=> !second_irq_pin)
        else $error("second pin asserted without sharing or request");

    chk_tx_raw: assert property (
        !ir_on && !alt_loc |=> second_port_tx_pin == $past(second_port_tx))
        else $error("standard format does not pass transmit data unchanged");

    chk_blank_start: assert property (
        s_tx_start |=> rx_blanked)
        else $error("half duplex transmit did not blank the receiver");

    chk_rx_forced: assert property (
        rx_blanked && ir_on |=> !second_port_rx)
        else $error("receive data not forced low while blanked");

    chk_mode_unused: assert property (
        req.rd && hit(req.addr, LDN_SECOND_PORT, IDX_PORT_MODE)
        |=> (rdata & ~MASK_SECOND_MODE) == 8'h00)
        else $error("second port mode read shows unused bits");

endmodule
`default_nettype wire

/* File: sim/sirc_xcvr.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// Infrared transceiver or serial line on the pin side
// ****************************************************************
module sirc_xcvr (
    // Clock
    input wire logic mclk,
    // Bench control
    input wire logic sel_alt,
    input wire logic rx_bit,
    // Receive pins of the device
    output logic rx_main,
    output logic rx_alt
);
    logic wiggle = 1'b0;
    logic main_q = 1'b1;
    logic alt_q = 1'b1;

    // Lines rest high until the first edge; one driver each
    assign rx_main = main_q;
    assign rx_alt = alt_q;

    // The line not in use toggles, so a wrong pin choice cannot pass by luck
    always @(posedge mclk) begin
        wiggle <= ~wiggle;
        main_q <= sel_alt ? wiggle : rx_bit;
        alt_q <= sel_alt ? rx_bit : wiggle;
    end
endmodule
`default_nettype wire

/* File: sim/serial_ir_mode_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_ir_mode_config_tb import sirc_pkg::*;;
    // ****************************************************************
    // Bench signals
    // ****************************************************************
    localparam int UNIT = 4;
    localparam logic [11:0] A_M1 = {LDN_FIRST_PORT, IDX_PORT_MODE};
    localparam logic [11:0] A_M2 = {LDN_SECOND_PORT, IDX_PORT_MODE};
    localparam logic [11:0] A_IR = {LDN_SECOND_PORT, IDX_IR_OPTION};
    localparam logic [11:0] A_TO = {LDN_SECOND_PORT, IDX_HD_TIMEOUT};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    sirc_req_s req = '0;
    logic [7:0] rdata;
    logic m1_midi, m1_hs, m2_midi, m2_hs;
    logic [2:0] ir_mode;
    logic irq1 = 1'b0;
    logic irq2 = 1'b0;
    logic pin1, pin2, rx_out, blanked;
    logic tx = 1'b0;
    logic rx_pin, alt_rx_pin, tx_pin, alt_tx_pin;
    logic sel_alt = 1'b0;
    logic rx_bit = 1'b1;
    int fails = 0;
    int n_checks = 0;
    int cycles = 0;

    // 125 MHz clock
    always #4 mclk = ~mclk;

    // Hang guard, far above the two hundred or so cycles the run needs
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            print_verdict;
        end
    end

    sirc_top #(.UNIT_CYCLES(UNIT)) dut (
        .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata),
        .first_midi_en(m1_midi), .first_high_speed(m1_hs),
        .second_midi_en(m2_midi), .second_high_speed(m2_hs), .ir_mode(ir_mode),
        .first_port_irq(irq1), .second_port_irq(irq2),
        .first_irq_pin(pin1), .second_irq_pin(pin2),
        .second_port_tx(tx), .second_port_rx(rx_out), .rx_blanked(blanked),
        .second_port_rx_pin(rx_pin), .alt_infrared_rx_pin(alt_rx_pin),
        .second_port_tx_pin(tx_pin), .alt_infrared_tx_pin(alt_tx_pin)
    );

    sirc_xcvr far_end (
        .mclk(mclk), .sel_alt(sel_alt), .rx_bit(rx_bit),
        .rx_main(rx_pin), .rx_alt(alt_rx_pin)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge mclk);
        req.wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge mclk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge mclk);
        req.rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rd(A_M1, 8'h00);
        rd(A_M2, 8'h00);
        rd(A_IR, 8'h02);
        rd(A_TO, 8'h03);
        rd(12'h3F0, 8'h00);
        chk("ir_mode", ir_mode, 3'h0);
        chk("mode outputs", {m1_midi, m1_hs, m2_midi, m2_hs}, 4'h0);
        chk("alt_infrared_tx_pin", alt_tx_pin, 1'b1);
    endtask

    task automatic t_regs;
        logic [11:0] a [4] = '{A_M1, A_M2, A_IR, A_TO};
        logic [7:0] m [4] = '{8'h83, 8'h03, 8'h7F, 8'hFF};
        for (int i = 0; i < 4; i++) begin
            wr(a[i], 8'hFF);
            rd(a[i], m[i]);
        end
        wr(A_M1, 8'h01);
        chk("first_midi_en", m1_midi, 1'b1);
        chk("first_high_speed", m1_hs, 1'b0);
        wr(A_M2, 8'h02);
        chk("second_midi_en", m2_midi, 1'b0);
        chk("second_high_speed", m2_hs, 1'b1);
    endtask

    // Every request pattern with sharing off and on
    task automatic t_irq;
        for (int s = 0; s < 2; s++) begin
            wr(A_M1, s ? 8'h80 : 8'h00);
            for (int v = 0; v < 4; v++) begin
                @(posedge mclk);
                irq1 <= v[0];
                irq2 <= v[1];
                cyc(1);
                chk("first_irq_pin", pin1, s ? (v[0] | v[1]) : v[0]);
                chk("second_irq_pin", pin2, s ? (v[0] | v[1]) : v[1]);
            end
        end
    endtask

    task automatic t_mode;
        for (int k = 0; k < 4; k++) begin
            wr(A_IR, 8'(k << 3));
            chk("ir_mode", ir_mode, 8'(k));
        end
    endtask

    // Bit 0 of k is the data, bit 1 the polarity, bit 2 the pin location
    task automatic t_tx;
        for (int k = 0; k < 8; k++) begin
            wr(A_IR, {1'b0, k[2], 3'b001, 1'b0, k[1], 1'b0});
            @(posedge mclk);
            tx <= k[0];
            cyc(1);
            chk("second_port_tx_pin", tx_pin, k[2] ? k[1] : k[0] ^ k[1]);
            chk("alt_infrared_tx_pin", alt_tx_pin, k[2] ? k[0] ^ k[1] : k[1]);
        end
        wr(A_IR, 8'h02);
        chk("second_port_tx_pin", tx_pin, 1'b1);
        @(posedge mclk);
        tx <= 1'b0;
        cyc(1);
        chk("second_port_tx_pin", tx_pin, 1'b0);
    endtask

    task automatic t_rx;
        for (int k = 0; k < 8; k++) begin
            wr(A_IR, {1'b0, k[2], 3'b001, 2'b00, k[1]});
            @(posedge mclk);
            sel_alt <= k[2];
            rx_bit <= k[0];
            cyc(5);
            chk("second_port_rx", rx_out, k[0] ^ k[1]);
        end
    endtask

    // Hold of two units after transmit, then zero timeout, then full duplex
    task automatic t_blank;
        wr(A_TO, 8'h02);
        wr(A_IR, 8'h0C);
        @(posedge mclk);
        sel_alt <= 1'b0;
        rx_bit <= 1'b1;
        tx <= 1'b1;
        cyc(4);
        chk("rx_blanked", blanked, 1'b1);
        chk("second_port_rx", rx_out, 1'b0);
        @(posedge mclk);
        tx <= 1'b0;
        // Low transmit is taken one edge later; the hold then lasts two units
        cyc(2 * UNIT);
        chk("rx_blanked", blanked, 1'b1);
        cyc(1);
        chk("rx_blanked", blanked, 1'b0);
        cyc(1);
        chk("second_port_rx", rx_out, 1'b1);
        wr(A_TO, 8'h00);
        @(posedge mclk);
        tx <= 1'b1;
        cyc(2);
        chk("rx_blanked", blanked, 1'b1);
        @(posedge mclk);
        tx <= 1'b0;
        cyc(1);
        chk("rx_blanked", blanked, 1'b0);
        wr(A_IR, 8'h08);
        @(posedge mclk);
        tx <= 1'b1;
        cyc(3);
        chk("rx_blanked", blanked, 1'b0);
        @(posedge mclk);
        tx <= 1'b0;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_regs;
        t_irq;
        t_mode;
        t_tx;
        t_rx;
        t_blank;
        print_verdict;
    end
endmodule
`default_nettype wire
